// >>> src/cecnt_bank.sv
// Purpose: Bank of three correctable error counters on control registers.
// Assumes: Register port reads combinationally decoded, data registered.
// Notes: Reads never disturb the counters.
`timescale 1ns/1ps
// Operation
// - The cache counter steps on a tag or data parity/ECC error.
// - Each register has a 5-bit threshold at 31:27 and 27-bit count.
// - When the selected count bit rises, the interrupt is asserted.
// - Thresholds 27 to 31 are stored as 26.
// - The interrupt is a level held while count reaches 2**thresh.
// - A write that resets the count clears the interrupt condition.
// - Reads have no side effect and writes set both fields at once.
// - The count wraps past its maximum without saturating.
// - The instruction memory counter steps on fetch or DMA errors.
// - The data memory counter steps on retired access or DMA errors.
// - DMA errors count in sleep halt and debug halt states too.
// - The registers sit at addresses 0x7F0, 0x7F1 and 0x7F2.
// - Any written value is accepted and only legal ones read back.
// - All fields reset to zero.
module cecnt_bank (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_csr_rd,
    input wire logic i_csr_wr,
    input wire logic [11:0] i_csr_addr,
    input wire logic [31:0] i_csr_wdata,
    input wire logic i_icache_tag_err,
    input wire logic i_icache_data_err,
    input wire logic i_itcm_fetch_err,
    input wire logic i_itcm_dma_err,
    input wire logic i_dtcm_ldst_err,
    input wire logic i_dtcm_retire,
    input wire logic i_dtcm_dma_err,
    output logic [31:0] o_csr_rdata,
    output logic o_csr_hit,
    output logic o_irq_icache,
    output logic o_irq_itcm,
    output logic o_irq_dtcm
);
    // ------------------------------------------------------------
    // Address decode and increment sources.
    // ------------------------------------------------------------
    wire logic [2:0] sel;
    wire logic [2:0] inc;
    wire logic [2:0] irq;
    wire logic [31:0] val [3];
    wire logic any_sel;
    wire logic [31:0] rd_mux;

    assign sel[cecnt_pkg::IDX_ICACHE] =
        i_csr_addr == cecnt_pkg::ADDR_ICACHE;
    assign sel[cecnt_pkg::IDX_ITCM] =
        i_csr_addr == cecnt_pkg::ADDR_ITCM;
    assign sel[cecnt_pkg::IDX_DTCM] =
        i_csr_addr == cecnt_pkg::ADDR_DTCM;
    assign any_sel = |sel;

    assign inc[cecnt_pkg::IDX_ICACHE] =
        i_icache_tag_err | i_icache_data_err;
    // DMA errors are not gated by any halt state.
    assign inc[cecnt_pkg::IDX_ITCM] =
        i_itcm_fetch_err | i_itcm_dma_err;
    assign inc[cecnt_pkg::IDX_DTCM] =
        (i_dtcm_ldst_err & i_dtcm_retire) | i_dtcm_dma_err;

    // ------------------------------------------------------------
    // Counter instances.
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < cecnt_pkg::NUM_CNT; g++) begin : g_cnt
            cecnt_counter u_cnt (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_wr(i_csr_wr & sel[g]),
                .i_wdata(i_csr_wdata),
                .i_inc(inc[g]),
                .o_value(val[g]),
                .o_irq(irq[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path, registered.
    // ------------------------------------------------------------
    assign rd_mux = sel[cecnt_pkg::IDX_ICACHE] ? val[cecnt_pkg::IDX_ICACHE] :
                    sel[cecnt_pkg::IDX_ITCM] ? val[cecnt_pkg::IDX_ITCM] :
                    sel[cecnt_pkg::IDX_DTCM] ? val[cecnt_pkg::IDX_DTCM] :
                    cecnt_pkg::REG_RESET;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_csr_rdata <= cecnt_pkg::REG_RESET;
            o_csr_hit <= 1'b0;
        end else begin
            o_csr_rdata <= i_csr_rd ? rd_mux : cecnt_pkg::REG_RESET;
            o_csr_hit <= (i_csr_rd | i_csr_wr) & any_sel;
        end
    end

    assign o_irq_icache = irq[cecnt_pkg::IDX_ICACHE];
    assign o_irq_itcm = irq[cecnt_pkg::IDX_ITCM];
    assign o_irq_dtcm = irq[cecnt_pkg::IDX_DTCM];

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    a_read_value: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_csr_rd && sel[cecnt_pkg::IDX_ITCM]) |=>
        o_csr_rdata == $past(val[cecnt_pkg::IDX_ITCM]))
        else $error("Read data does not match the register.");
    a_dtcm_spec: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_dtcm_ldst_err && !i_dtcm_retire && !i_dtcm_dma_err && !i_csr_wr)
        |=> $stable(val[cecnt_pkg::IDX_DTCM]))
        else $error("Speculative error was counted.");
    a_reset_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_csr_wr && sel[cecnt_pkg::IDX_ICACHE] && i_csr_wdata[26:0] == 27'h0)
        |=> !o_irq_icache)
        else $error("Interrupt survived a count reset.");
    c_rd_hit: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_csr_rd && any_sel);
    c_dma_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_itcm_dma_err ##1 $rose(o_irq_itcm));
endmodule

// >>> include/cecnt_pkg.sv
// Purpose: Shared constants for the correctable error counter bank.
// Assumes: One core clock, 12-bit control-register addresses.
// Notes: Register layout is threshold in the top bits, count below.
package cecnt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int NUM_CNT = 3;
    localparam int CNT_W = 27;
    localparam int THR_W = 5;
    localparam int THR_LSB = 27;
    localparam int THR_MSB = 31;
    localparam int CNT_LSB = 0;
    localparam int CNT_MSB = 26;
    localparam logic [THR_W-1:0] THR_MAX = 5'h1A;
    localparam logic [ADDR_W-1:0] ADDR_ICACHE = 12'h7F0;
    localparam logic [ADDR_W-1:0] ADDR_ITCM = 12'h7F1;
    localparam logic [ADDR_W-1:0] ADDR_DTCM = 12'h7F2;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 27'h000_0001;
    localparam int IDX_ICACHE = 0;
    localparam int IDX_ITCM = 1;
    localparam int IDX_DTCM = 2;
endpackage

// >>> src/cecnt_counter.sv
// Purpose: One error counter with threshold and level interrupt.
// Assumes: Write and increment are single-cycle pulses on i_clk.
// Notes: Read data is the stored register, always legal.
`timescale 1ns/1ps
module cecnt_counter (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    input wire logic i_inc,
    output logic [31:0] o_value,
    output logic o_irq
);
    // ------------------------------------------------------------
    // Threshold legalisation and count update.
    // ------------------------------------------------------------
    logic [4:0] thr_reg;
    logic [4:0] thr_next;
    logic [26:0] cnt_reg;
    logic [26:0] cnt_next;
    logic irq_next;
    wire logic [4:0] wr_thr;
    wire logic [26:0] wr_cnt;
    wire logic thr_bad;
    wire logic [27:0] cnt_sum;
    wire logic sel_bit_next;
    wire logic [4:0] thr_legal;

    assign wr_thr = i_wdata[cecnt_pkg::THR_MSB:cecnt_pkg::THR_LSB];
    assign wr_cnt = i_wdata[cecnt_pkg::CNT_MSB:cecnt_pkg::CNT_LSB];
    assign thr_bad = wr_thr > cecnt_pkg::THR_MAX;
    assign thr_legal = thr_bad ? cecnt_pkg::THR_MAX : wr_thr;
    // Counter wraps, no saturation.
    assign cnt_sum = {1'b0, cnt_reg} + {1'b0, cecnt_pkg::CNT_ONE};
    // Write wins and replaces both fields at once.
    assign thr_next = i_wr ? thr_legal : thr_reg;
    assign cnt_next = i_wr ? wr_cnt :
                      (i_inc ? cnt_sum[26:0] : cnt_reg);
    assign sel_bit_next = cnt_next[thr_next];
    // Level interrupt: count >= 2**thresh, i.e. any bit at or above it.
    always_comb begin
        irq_next = 1'b0;
        for (int b = 0; b < cecnt_pkg::CNT_W; b++) begin
            if (b >= int'(thr_next) && cnt_next[b]) begin
                irq_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            thr_reg <= cecnt_pkg::REG_RESET[cecnt_pkg::THR_MSB:
                                            cecnt_pkg::THR_LSB];
            cnt_reg <= cecnt_pkg::REG_RESET[cecnt_pkg::CNT_MSB:
                                            cecnt_pkg::CNT_LSB];
            o_irq <= 1'b0;
        end else begin
            thr_reg <= thr_next;
            cnt_reg <= cnt_next;
            o_irq <= irq_next;
        end
    end

    assign o_value = {thr_reg, cnt_reg};

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    a_thr_legal: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        thr_reg <= cecnt_pkg::THR_MAX)
        else $error("Threshold holds an illegal value.");
    a_inc_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_inc && !i_wr) |=> cnt_reg == $past(cnt_reg) + 27'h000_0001)
        else $error("Count did not step by one.");
    a_wr_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr |=> cnt_reg == $past(wr_cnt))
        else $error("Written count not stored.");
    a_irq_level: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        o_irq == ((cnt_reg >> thr_reg) != 27'h000_0000))
        else $error("Interrupt does not match count and threshold.");
    a_hold_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_wr && !i_inc) |=> $stable(o_value))
        else $error("Register changed without cause.");
    a_cross_irq: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(sel_bit_next) && !i_wr |=> o_irq)
        else $error("Threshold crossing gave no interrupt.");
    c_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_inc && !i_wr && cnt_reg == 27'h7FF_FFFF);
    c_irq_rise: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_irq));
    c_wr_inc: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        i_wr && i_inc);
endmodule

// >>> sim/cecnt_err_src.sv
// Purpose: Memory error detector model that emits error pulses.
// Assumes: A burst request is sampled at the falling clock edge.
// Notes: Line 4 adds retire, 5 hits both cache lines, 7 lacks retire.
`timescale 1ns/1ps
module cecnt_err_src (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [2:0] i_line,
    input wire logic [7:0] i_n,
    output logic [6:0] o_err = 7'h00
);
    logic [7:0] left = 8'h00;
    logic [2:0] sel = 3'h0;
    always @(negedge i_clk) begin
        {left, sel} = i_go ? {i_n, i_line} : {left, sel};
        o_err <= left == 8'h00 ? 7'h00 : sel == 3'h4 ? 7'h30
            : sel == 3'h5 ? 7'h03 : sel == 3'h7 ? 7'h10 : 7'h01 << sel;
        left = left - 8'(left != 8'h00);
    end
endmodule

// >>> sim/cecnt_bank_tb.sv
// Purpose: Self-checking bench for the error counter bank.
// Assumes: Inputs change at the falling clock edge.
// Notes: The exp_reg array holds what each register should read.
`timescale 1ns/1ps
module cecnt_bank_tb;
    logic i_clk = 1'b0, i_rst_n = 1'b0, rd = 1'b0, wr = 1'b0, go = 1'b0, hit;
    logic [2:0] line = 3'h0, irq;
    logic [6:0] err;
    logic [7:0] num = 8'h00;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [31:0] exp_reg [3] = '{default: 32'h0000_0000};
    int n_fail = 0, cmp_count = 0;
    initial forever #50 i_clk = ~i_clk;
    cecnt_err_src cecnt_err_src_i (.i_clk(i_clk), .i_go(go), .i_line(line),
        .i_n(num), .o_err(err));
    cecnt_bank cecnt_bank_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_csr_rd(rd),
        .i_csr_wr(wr), .i_csr_addr(addr), .i_csr_wdata(wdata), .o_csr_hit(hit),
        .i_icache_tag_err(err[0]), .i_icache_data_err(err[1]),
        .i_itcm_fetch_err(err[2]), .i_itcm_dma_err(err[3]), .o_csr_rdata(rdata),
        .i_dtcm_ldst_err(err[4]), .i_dtcm_retire(err[5]), .i_dtcm_dma_err(err[6]),
        .o_irq_icache(irq[0]), .o_irq_itcm(irq[1]), .o_irq_dtcm(irq[2]));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) n_fail++;
        if (g !== e) $display("mismatch %s expected %h seen %h", nm, e, g);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
        logic m;
        logic [31:0] e;
        m = a inside {[12'h7F0:12'h7F2]};
        e = m ? exp_reg[a[1:0]] : 32'h0000_0000;
        @(negedge i_clk) {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(negedge i_clk) {wr, rd} <= 2'b00;
        chk("hit", 32'(m), 32'(hit));
        if (w && m) exp_reg[a[1:0]] = d[31:27] > 5'h1A ? {5'h1A, d[26:0]} : d;
        if (!w) chk("rdata", e, rdata);
        if (!w) chk("irq", 32'(|(e[26:0] >> e[31:27])),
            32'(irq[a[1:0]] & m));
    endtask
    task automatic chk_all;
        for (int i = 0; i < 4; i++) acc(1'b0, 12'h7F0 + 12'(i), 32'h0);
    endtask
    task automatic errs(logic [2:0] ln, logic [7:0] n, int ix, int c);
        @(negedge i_clk) {go, line, num} <= {1'b1, ln, n};
        @(negedge i_clk) go <= 1'b0;
        repeat (n) @(negedge i_clk);
        exp_reg[ix][26:0] += 27'(c);
        chk_all;
    endtask
    task automatic t_fields;
        chk_all;
        for (int t = 0; t < 32; t++) begin
            acc(1'b1, 12'h7F1, {5'(t), 27'h2AA_AAAA});
            acc(1'b0, 12'h7F1, 32'h0000_0000);
        end
        acc(1'b1, 12'h7F3, 32'h1234_5678);
        $display("test fields done");
    endtask
    task automatic t_count;
        acc(1'b1, 12'h7F1, 32'h1000_0000);
        errs(3'h2, 8'h03, 1, 3);
        errs(3'h3, 8'h01, 1, 1);
        acc(1'b1, 12'h7F1, 32'h1000_0000);
        errs(3'h1, 8'h02, 0, 2);
        errs(3'h5, 8'h03, 0, 3);
        acc(1'b1, 12'h7F2, 32'hD7FF_FFFE);
        errs(3'h7, 8'h03, 2, 0);
        errs(3'h4, 8'h01, 2, 1);
        errs(3'h6, 8'h01, 2, 1);
        $display("test count done");
    endtask
    task automatic t_collide;
        fork
            errs(3'h3, 8'h04, 1, 3);
            @(negedge i_clk) acc(1'b1, 12'h7F1, 32'h0000_0000);
        join
        // Firmware keeps the instruction memory threshold at 16 or more.
        acc(1'b1, 12'h7F1, 32'h8000_0000);
        errs(3'h3, 8'h02, 1, 2);
        $display("test collide done");
    endtask
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst_n <= 1'b1;
        t_fields;
        t_count;
        t_collide;
        stop_test;
    end
endmodule
